// [hw/arb_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
  import hub_pkg::*;
  logic [NUM_MASKABLE-1:0] elig;
  logic [NUM_MASKABLE-1:0][2:0] prio;
  logic win_valid;
  logic [5:0] win_idx;
  logic [2:0] win_prio;
  modport hub (output elig, output prio, input win_valid, input win_idx,
    input win_prio);
  modport arb (input elig, input prio, output win_valid, output win_idx,
    output win_prio);
endinterface
`default_nettype wire

// [hw/hub_pkg.sv]
// How it works
// - One non-maskable request and 35 maskable requests, each with a control register.
// - A pending trap or undefined-opcode exception is offered before any interrupt.
// - Each maskable request has a three-bit priority; lower value wins arbitration.
// - A request whose mask bit is set is never offered to the core.
// - Requests at or below the priority-mask level are blocked.
// - Non-maskable entry uses code 0x0010, handler 0x10, return is next instruction.
// - Trap vectors 0-15 give 0x0040+n at 0x40; 16-31 give 0x0050+n-16 at 0x50.
// - An undefined opcode gives code 0x0060 and handler 0x60.
// - Among equal programmed priorities the lowest default number 0..34 wins.
// - DMA completions are defaults 22-25, codes 0x02a0-0x02d0, handler equals code.
// - Capture/compare or pin requests 4-19 from 0x0100; overflows 0-3 from 0x0080.
// - A four-bit select per timer unit picks pin or compare source; only it counts.
// - Serial requests are defaults 26-33 with codes 0x0300 to 0x0370.
// - Conversion completion is lowest default priority, code and handler 0x0400.
// - On acceptance the next instruction address goes to the matching return register.
// - If a divide is executing, an interrupt saves the divide's own address instead; exceptions do not.
// - Pin requests have software-selected noise filter, edge detection and valid edge.
// - Non-maskable pin fires on rising or falling edge chosen by edge-select bit 0.
// - While non-maskable service runs, new ones wait; at most one is kept.
// - Masked or blocked maskable requests stay pending until acceptable.
// - Accepting a maskable request sets disable flag; only strictly higher levels nest.
package hub_pkg;
  localparam int NUM_MASKABLE = 35;
  localparam int NUM_PINS = 9;
  localparam int NUM_UNITS = 4;
  localparam int NUM_LEVELS = 8;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_NS = 60;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LEVEL_NONE = 4'h8;

  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] CODE_NMI = 16'h0010;
  localparam logic [15:0] CODE_TRAP_LO = 16'h0040;
  localparam logic [15:0] CODE_TRAP_HI = 16'h0050;
  localparam logic [15:0] CODE_UNDEF = 16'h0060;
  localparam logic [31:0] HANDLER_RESET = 32'h00000000;
  localparam logic [31:0] HANDLER_NMI = 32'h00000010;
  localparam logic [31:0] HANDLER_TRAP_LO = 32'h00000040;
  localparam logic [31:0] HANDLER_TRAP_HI = 32'h00000050;
  localparam logic [31:0] HANDLER_UNDEF = 32'h00000060;

  localparam int CC_FIRST = 4;
  localparam int CM_FIRST = 20;
  localparam int SER_FIRST = 26;
  localparam int CONV_IDX = 34;
  localparam logic [15:0] OVF_BASE = 16'h0080;
  localparam logic [15:0] CC_BASE = 16'h0100;
  localparam logic [15:0] CM_BASE = 16'h0280;
  localparam logic [15:0] SER_BASE = 16'h0300;
  localparam logic [15:0] CONV_CODE = 16'h0400;
  localparam logic [15:0] CODE_STEP = 16'h0010;

  localparam logic [5:0] REG_EXT_MODE = 6'h23;
  localparam logic [5:0] REG_TUM0 = 6'h24;
  localparam logic [5:0] REG_PRIO_MASK = 6'h28;
  localparam logic [5:0] REG_PIN_EDGE = 6'h29;
  localparam logic [5:0] REG_PIN_FILT = 6'h2a;
  localparam logic [5:0] REG_CAUSE = 6'h2b;
  localparam logic [5:0] REG_MASKABLE_RETURN_PC = 6'h2c;
  localparam logic [5:0] REG_NMI_RETURN_PC = 6'h2d;
  localparam logic [5:0] REG_STATUS = 6'h2e;
  localparam int CTL_PEND_BIT = 7;
  localparam int CTL_MASK_BIT = 6;
  localparam logic CTL_MASK_RST = 1'b1;
  localparam logic [2:0] CTL_PRIO_RST = 3'h7;
  localparam logic EXT_MODE_RST = 1'b0;
  localparam logic [3:0] TUM_RST = 4'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  typedef enum logic [2:0] {EV_RESET, EV_TRAP, EV_UNDEF, EV_NMI, EV_MASK}
    evt_kind_t;
  typedef enum logic {ST_BOOT, ST_RUN} hub_state_t;

  // Pins 0..7 share sources 4..11; pin 8 shares source 16.
  function automatic int pin_src(input int p);
    pin_src = (p < 8) ? CC_FIRST + p : CC_FIRST + 12;
  endfunction

  function automatic int pin_unit(input int p);
    pin_unit = (p < 8) ? p / 4 : 3;
  endfunction

  function automatic logic [15:0] code_of(input int i);
    if (i < CC_FIRST) code_of = OVF_BASE + 16'(i) * CODE_STEP;
    else if (i < CM_FIRST) code_of = CC_BASE + 16'(i - CC_FIRST) * CODE_STEP;
    else if (i < SER_FIRST) code_of = CM_BASE + 16'(i - CM_FIRST) * CODE_STEP;
    else if (i < CONV_IDX) code_of = SER_BASE + 16'(i - SER_FIRST) * CODE_STEP;
    else code_of = CONV_CODE;
  endfunction
endpackage

// [hw/interrupt_hub.sv]
`timescale 1ns/1ps
`default_nettype none
module interrupt_hub
  import hub_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [5:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic NMI_PIN,
  input wire logic [NUM_PINS-1:0] TIMER_PIN_REQUEST,
  input wire logic [NUM_MASKABLE-1:0] PERIPH_REQ,
  input wire logic TRAP_REQ,
  input wire logic [4:0] TRAP_VEC,
  input wire logic UNDEF_OPCODE_TRAP,
  input wire logic DIV_BUSY,
  input wire logic [31:0] CUR_PC,
  input wire logic [31:0] FOLLOWING_INSTR_ADDR,
  input wire logic CORE_EI,
  input wire logic CORE_DI,
  input wire logic CORE_RETI,
  output logic EVT_VALID,
  output logic [15:0] EVT_CODE,
  output logic [31:0] EVT_HANDLER,
  input wire logic EVT_ACK,
  output logic IRQ_DISABLE_FLAG,
  output logic NMI_SERVICE_FLAG,
  output logic [31:0] MASKABLE_RETURN_PC,
  output logic [31:0] NMI_RETURN_PC
);
  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_MASKABLE-1:0] mask_r, mask_nxt, sw_clr;
  logic [NUM_MASKABLE-1:0][2:0] prio_r, prio_nxt;
  logic nmi_edge_select_r, nmi_edge_select_nxt;
  logic [NUM_UNITS-1:0][3:0] tum_r, tum_nxt;
  logic [3:0] pmask_r, pmask_nxt;
  logic [2*NUM_PINS-1:0] edge_r, edge_nxt;
  logic [NUM_PINS-1:0] filt_r, filt_nxt;

  always_comb begin
    mask_nxt = mask_r;
    prio_nxt = prio_r;
    nmi_edge_select_nxt = nmi_edge_select_r;
    tum_nxt = tum_r;
    pmask_nxt = pmask_r;
    edge_nxt = edge_r;
    filt_nxt = filt_r;
    sw_clr = '0;
    if (REG_WR) begin
      for (int i = 0; i < NUM_MASKABLE; i++) begin
        if (REG_ADDR == 6'(i)) begin
          mask_nxt[i] = REG_WDATA[CTL_MASK_BIT];
          prio_nxt[i] = REG_WDATA[2:0];
          sw_clr[i] = !REG_WDATA[CTL_PEND_BIT];
        end
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (REG_ADDR == REG_TUM0 + 6'(u)) tum_nxt[u] = REG_WDATA[3:0];
      end
      case (REG_ADDR)
        REG_EXT_MODE: nmi_edge_select_nxt = REG_WDATA[0];
        REG_PRIO_MASK: pmask_nxt = REG_WDATA[3:0];
        REG_PIN_EDGE: edge_nxt = REG_WDATA[2*NUM_PINS-1:0];
        REG_PIN_FILT: filt_nxt = REG_WDATA[NUM_PINS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_r <= {NUM_MASKABLE{CTL_MASK_RST}};
      prio_r <= {NUM_MASKABLE{CTL_PRIO_RST}};
      nmi_edge_select_r <= EXT_MODE_RST;
      tum_r <= {NUM_UNITS{TUM_RST}};
      pmask_r <= LEVEL_NONE;
      edge_r <= '0;
      filt_r <= '0;
    end else begin
      mask_r <= mask_nxt;
      prio_r <= prio_nxt;
      nmi_edge_select_r <= nmi_edge_select_nxt;
      tum_r <= tum_nxt;
      pmask_r <= pmask_nxt;
      edge_r <= edge_nxt;
      filt_r <= filt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_PINS-1:0] pin_evt;
  logic nmi_evt;

  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      pin_edge u_pin (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .pin(TIMER_PIN_REQUEST[p]),
        .filt_en(filt_r[p]),
        .mode(edge_r[2*p +: 2]),
        .evt(pin_evt[p])
      );
    end
  endgenerate

  // The pin has its own analog filter ahead of us, so filtering stays on.
  pin_edge u_nmi (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin(NMI_PIN),
    .filt_en(1'b1),
    .mode(nmi_edge_select_r ? EDGE_RISE : EDGE_FALL),
    .evt(nmi_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_MASKABLE-1:0] pend_r, pend_nxt;
  logic [NUM_LEVELS-1:0] isr_r, isr_nxt;
  logic [NUM_MASKABLE-1:0] src_evt;
  logic [3:0] cur_lvl;
  arb_if arb ();

  always_comb begin
    src_evt = PERIPH_REQ;
    for (int p = 0; p < NUM_PINS; p++) begin
      src_evt[pin_src(p)] = tum_r[pin_unit(p)][p % 4] ? pin_evt[p]
                                                      : PERIPH_REQ[pin_src(p)];
    end
    cur_lvl = LEVEL_NONE;
    for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
      if (isr_r[l]) cur_lvl = 4'(l);
    end
    for (int i = 0; i < NUM_MASKABLE; i++) begin
      arb.elig[i] = pend_r[i] && !mask_r[i]
                    && {1'b0, prio_r[i]} < pmask_r
                    && {1'b0, prio_r[i]} < cur_lvl;
    end
    arb.prio = prio_r;
  end

  prio_arbiter u_arb (
    .a(arb.arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic id_r, id_nxt, np_r, np_nxt, nmi_pend_r, nmi_pend_nxt;
  logic trap_pend_r, trap_pend_nxt, undef_pend_r, undef_pend_nxt;
  logic [4:0] trap_vec_r, trap_vec_nxt;
  logic [31:0] cause_r, cause_nxt, maskable_return_pc_r, maskable_return_pc_nxt, nmi_return_pc_r, nmi_return_pc_nxt;
  hub_state_t state_r, state_nxt;
  evt_kind_t evt_kind_r, evt_kind_nxt, cand_kind;
  logic evt_valid_r, evt_valid_nxt, cand_valid, take;
  logic [15:0] evt_code_r, evt_code_nxt, cand_code;
  logic [31:0] evt_handler_r, evt_handler_nxt, cand_handler, ret_pc;
  logic [5:0] evt_idx_r, evt_idx_nxt;
  logic [2:0] evt_prio_r, evt_prio_nxt;

  // Exceptions are tested first because they stem from the running code.
  always_comb begin
    cand_valid = 1'b1;
    cand_kind = EV_MASK;
    cand_code = code_of(int'(arb.win_idx));
    cand_handler = {16'h0000, code_of(int'(arb.win_idx))};
    if (undef_pend_r) begin
      cand_kind = EV_UNDEF;
      cand_code = CODE_UNDEF;
      cand_handler = HANDLER_UNDEF;
    end else if (trap_pend_r) begin
      cand_kind = EV_TRAP;
      cand_code = (trap_vec_r[4] ? CODE_TRAP_HI : CODE_TRAP_LO)
                  + {12'h000, trap_vec_r[3:0]};
      cand_handler = trap_vec_r[4] ? HANDLER_TRAP_HI : HANDLER_TRAP_LO;
    end else if (nmi_pend_r && !np_r) begin
      cand_kind = EV_NMI;
      cand_code = CODE_NMI;
      cand_handler = HANDLER_NMI;
    end else if (!(arb.win_valid && !id_r && !np_r)) begin
      cand_valid = 1'b0;
    end
  end

  assign take = EVT_ACK && evt_valid_r;
  assign ret_pc = DIV_BUSY ? CUR_PC : FOLLOWING_INSTR_ADDR;

  always_comb begin
    pend_nxt = pend_r & ~sw_clr;
    isr_nxt = isr_r;
    id_nxt = id_r;
    np_nxt = np_r;
    nmi_pend_nxt = nmi_pend_r;
    trap_pend_nxt = trap_pend_r;
    undef_pend_nxt = undef_pend_r;
    trap_vec_nxt = TRAP_REQ ? TRAP_VEC : trap_vec_r;
    cause_nxt = cause_r;
    maskable_return_pc_nxt = maskable_return_pc_r;
    nmi_return_pc_nxt = nmi_return_pc_r;
    state_nxt = state_r;
    evt_valid_nxt = cand_valid && !take;
    evt_kind_nxt = cand_kind;
    evt_code_nxt = cand_code;
    evt_handler_nxt = cand_handler;
    evt_idx_nxt = arb.win_idx;
    evt_prio_nxt = arb.win_prio;
    if (CORE_EI) id_nxt = 1'b0;
    if (CORE_DI) id_nxt = 1'b1;
    if (CORE_RETI) begin
      id_nxt = 1'b0;
      if (np_r) np_nxt = 1'b0;
      else if (cur_lvl != LEVEL_NONE) isr_nxt[cur_lvl[2:0]] = 1'b0;
    end
    if (state_r == ST_BOOT) begin
      evt_valid_nxt = !take;
      evt_kind_nxt = EV_RESET;
      evt_code_nxt = CODE_RESET;
      evt_handler_nxt = HANDLER_RESET;
      if (take) state_nxt = ST_RUN;
    end else if (take) begin
      case (evt_kind_r)
        EV_MASK: begin
          pend_nxt[evt_idx_r] = 1'b0;
          isr_nxt[evt_prio_r] = 1'b1;
          id_nxt = 1'b1;
          maskable_return_pc_nxt = ret_pc;
          cause_nxt[15:0] = evt_code_r;
        end
        EV_NMI: begin
          nmi_pend_nxt = 1'b0;
          np_nxt = 1'b1;
          id_nxt = 1'b1;
          nmi_return_pc_nxt = ret_pc;
          cause_nxt[31:16] = evt_code_r;
        end
        EV_TRAP, EV_UNDEF: begin
          trap_pend_nxt = trap_pend_r && evt_kind_r != EV_TRAP;
          undef_pend_nxt = undef_pend_r && evt_kind_r != EV_UNDEF;
          id_nxt = 1'b1;
          maskable_return_pc_nxt = FOLLOWING_INSTR_ADDR;
          cause_nxt[15:0] = evt_code_r;
        end
        default: ;
      endcase
    end
    // New arrivals are applied last so that they beat a clear.
    pend_nxt = pend_nxt | src_evt;
    nmi_pend_nxt = nmi_pend_nxt | nmi_evt;
    trap_pend_nxt = trap_pend_nxt | TRAP_REQ;
    undef_pend_nxt = undef_pend_nxt | UNDEF_OPCODE_TRAP;
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_r <= '0;
      isr_r <= '0;
      id_r <= 1'b1;
      np_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      trap_pend_r <= 1'b0;
      undef_pend_r <= 1'b0;
      trap_vec_r <= 5'h00;
      cause_r <= 32'h00000000;
      maskable_return_pc_r <= 32'h00000000;
      nmi_return_pc_r <= 32'h00000000;
      state_r <= ST_BOOT;
      evt_valid_r <= 1'b1;
      evt_kind_r <= EV_RESET;
      evt_code_r <= CODE_RESET;
      evt_handler_r <= HANDLER_RESET;
      evt_idx_r <= 6'h00;
      evt_prio_r <= 3'h0;
    end else begin
      pend_r <= pend_nxt;
      isr_r <= isr_nxt;
      id_r <= id_nxt;
      np_r <= np_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      trap_pend_r <= trap_pend_nxt;
      undef_pend_r <= undef_pend_nxt;
      trap_vec_r <= trap_vec_nxt;
      cause_r <= cause_nxt;
      maskable_return_pc_r <= maskable_return_pc_nxt;
      nmi_return_pc_r <= nmi_return_pc_nxt;
      state_r <= state_nxt;
      evt_valid_r <= evt_valid_nxt;
      evt_kind_r <= evt_kind_nxt;
      evt_code_r <= evt_code_nxt;
      evt_handler_r <= evt_handler_nxt;
      evt_idx_r <= evt_idx_nxt;
      evt_prio_r <= evt_prio_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (REG_RD) begin
      for (int i = 0; i < NUM_MASKABLE; i++) begin
        if (REG_ADDR == 6'(i)) begin
          rdata_nxt[CTL_PEND_BIT] = pend_r[i];
          rdata_nxt[CTL_MASK_BIT] = mask_r[i];
          rdata_nxt[2:0] = prio_r[i];
        end
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (REG_ADDR == REG_TUM0 + 6'(u)) rdata_nxt[3:0] = tum_r[u];
      end
      case (REG_ADDR)
        REG_EXT_MODE: rdata_nxt[0] = nmi_edge_select_r;
        REG_PRIO_MASK: rdata_nxt[3:0] = pmask_r;
        REG_PIN_EDGE: rdata_nxt[2*NUM_PINS-1:0] = edge_r;
        REG_PIN_FILT: rdata_nxt[NUM_PINS-1:0] = filt_r;
        REG_CAUSE: rdata_nxt = cause_r;
        REG_MASKABLE_RETURN_PC: rdata_nxt = maskable_return_pc_r;
        REG_NMI_RETURN_PC: rdata_nxt = nmi_return_pc_r;
        REG_STATUS: rdata_nxt[10:0] = {isr_r, np_r, id_r, nmi_pend_r};
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) rdata_r <= 32'h00000000;
    else rdata_r <= rdata_nxt;
  end

  assign REG_RDATA = rdata_r;
  assign EVT_VALID = evt_valid_r;
  assign EVT_CODE = evt_code_r;
  assign EVT_HANDLER = evt_handler_r;
  assign IRQ_DISABLE_FLAG = id_r;
  assign NMI_SERVICE_FLAG = np_r;
  assign MASKABLE_RETURN_PC = maskable_return_pc_r;
  assign NMI_RETURN_PC = nmi_return_pc_r;

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_MASKABLE-1:0] elig_q;
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) elig_q <= '0;
    else elig_q <= arb.elig;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence s_take_mask;
    take && evt_kind_r == EV_MASK;
  endsequence
  sequence s_take_nmi;
    take && evt_kind_r == EV_NMI;
  endsequence
  sequence s_exc_waiting;
    state_r == ST_RUN && !take && (undef_pend_r || trap_pend_r);
  endsequence

  boot_vector_a:
  assert property (state_r == ST_BOOT |-> EVT_VALID && EVT_CODE == CODE_RESET
    && EVT_HANDLER == HANDLER_RESET) else $error("reset entry not shown");
  exc_first_a:
  assert property (s_exc_waiting |=> EVT_VALID
    && (evt_kind_r == EV_TRAP || evt_kind_r == EV_UNDEF))
    else $error("exception not offered first");
  nmi_vector_a:
  assert property (EVT_VALID && evt_kind_r == EV_NMI |-> EVT_CODE == CODE_NMI
    && EVT_HANDLER == HANDLER_NMI) else $error("wrong nmi vector");
  undef_vector_a:
  assert property (EVT_VALID && evt_kind_r == EV_UNDEF |->
    EVT_CODE == CODE_UNDEF && EVT_HANDLER == HANDLER_UNDEF)
    else $error("wrong undefined opcode vector");
  mask_gate_a:
  assert property (EVT_VALID && evt_kind_r == EV_MASK |-> elig_q[evt_idx_r])
    else $error("masked request offered");
  level_mask_a:
  assert property (EVT_VALID && evt_kind_r == EV_MASK |->
    {1'b0, evt_prio_r} < $past(pmask_r)) else $error("level mask ignored");
  nest_entry_a:
  assert property (s_take_mask |=> IRQ_DISABLE_FLAG
    && isr_r[$past(evt_prio_r)]) else $error("nesting state not set");
  nmi_hold_a:
  assert property (np_r |=> !(EVT_VALID && evt_kind_r == EV_NMI))
    else $error("nmi offered during nmi service");
  div_return_a:
  assert property (s_take_mask and DIV_BUSY |=> maskable_return_pc_r == $past(CUR_PC))
    else $error("divide address not saved");
  nmi_return_a:
  assert property (s_take_nmi and !DIV_BUSY |=>
    nmi_return_pc_r == $past(FOLLOWING_INSTR_ADDR) && cause_r[31:16] == CODE_NMI)
    else $error("nmi return address wrong");
endmodule
`default_nettype wire

// [hw/pin_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_edge
  import hub_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic filt_en,
  input wire logic [1:0] mode,
  output logic evt
);
  logic s1_r, s2_r, lvl_r, lvl_nxt, evt_r, evt_nxt;
  logic [1:0] cnt_r, cnt_nxt;

  // A change must persist for the filter time before it is believed.
  always_comb begin
    lvl_nxt = lvl_r;
    cnt_nxt = 2'h0;
    if (!filt_en) begin
      lvl_nxt = s2_r;
    end else if (s2_r != lvl_r) begin
      if (cnt_r == 2'(FILTER_CYCLES - 1)) begin
        lvl_nxt = s2_r;
      end else begin
        cnt_nxt = cnt_r + 2'h1;
      end
    end
    evt_nxt = (lvl_nxt & ~lvl_r & mode[0]) | (~lvl_nxt & lvl_r & mode[1]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      lvl_r <= 1'b0;
      cnt_r <= 2'h0;
      evt_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign evt = evt_r;
endmodule
`default_nettype wire

// [hw/prio_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter
  import hub_pkg::*;
(
  arb_if.arb a
);
  // Strict compare keeps the lower default number on a tie.
  always_comb begin
    a.win_valid = 1'b0;
    a.win_idx = 6'h00;
    a.win_prio = 3'h7;
    for (int i = 0; i < NUM_MASKABLE; i++) begin
      if (a.elig[i] && (!a.win_valid || a.prio[i] < a.win_prio)) begin
        a.win_valid = 1'b1;
        a.win_idx = 6'(i);
        a.win_prio = a.prio[i];
      end
    end
  end
endmodule
`default_nettype wire

// [tb/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Stands in for the processor core: it takes every offered entry after a
// wait of 0 to 3 cycles, so both prompt and slow acceptance are exercised.
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic evt_valid,
  input wire logic [1:0] dly,
  output logic ack
);
  logic [1:0] cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      cnt_r <= 2'h0;
    end else if (ack) begin
      // One cycle of acknowledge only; the entry is gone after it.
      ack <= 1'b0;
      cnt_r <= 2'h0;
    end else if (evt_valid) begin
      if (cnt_r == dly) ack <= 1'b1;
      else cnt_r <= cnt_r + 2'h1;
    end else begin
      cnt_r <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// [tb/test_interrupt_hub.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_interrupt_hub;
  import hub_pkg::*;
  logic clk, rst, wr_s, rd_s, nmi, trap, undef, div, ei, reti, ack;
  logic evt_valid, id_f, np_f;
  logic [5:0] addr;
  logic [4:0] vec;
  logic [1:0] dly;
  logic [31:0] wdata, rdata, cur, fol, maskable_return_pc, nmi_return_pc, hnd, d, rs;
  logic [15:0] code;
  logic [34:0] preq;
  logic [8:0] pins;
  int num_errors, num_checks, a, b, i;

  interrupt_hub interrupt_hub_i (.CLK_SYS(clk), .SYS_RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_RDATA(rdata), .NMI_PIN(nmi), .TIMER_PIN_REQUEST(pins),
    .PERIPH_REQ(preq), .TRAP_REQ(trap), .TRAP_VEC(vec),
    .UNDEF_OPCODE_TRAP(undef), .DIV_BUSY(div), .CUR_PC(cur),
    .FOLLOWING_INSTR_ADDR(fol), .CORE_EI(ei), .CORE_DI(1'b0),
    .CORE_RETI(reti), .EVT_VALID(evt_valid), .EVT_CODE(code),
    .EVT_HANDLER(hnd), .EVT_ACK(ack), .IRQ_DISABLE_FLAG(id_f),
    .NMI_SERVICE_FLAG(np_f), .MASKABLE_RETURN_PC(maskable_return_pc),
    .NMI_RETURN_PC(nmi_return_pc));
  core_model core_model_i (.clk(clk), .rst(rst), .evt_valid(evt_valid),
    .dly(dly), .ack(ack));

  function automatic logic [31:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction

  // Expected code of a maskable source from its default priority.
  function automatic logic [15:0] ecode(input int k);
    if (k < 4) ecode = 16'h0080 + 16'(k << 4);
    else if (k < 20) ecode = 16'h0100 + 16'((k - 4) << 4);
    else if (k < 26) ecode = 16'h0280 + 16'((k - 20) << 4);
    else if (k < 34) ecode = 16'h0300 + 16'((k - 26) << 4);
    else ecode = 16'h0400;
  endfunction

  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [5:0] ad, input logic [31:0] dt);
    @(posedge clk);
    addr <= ad;
    wdata <= dt;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] ad, output logic [31:0] dt);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    dt = rdata;
  endtask

  // Fresh return addresses ride along with every request burst.
  task automatic req(input logic [34:0] v);
    @(posedge clk);
    preq <= v;
    cur <= rnd();
    fol <= rnd();
    div <= rs[3];
    @(posedge clk);
    preq <= '0;
  endtask

  task automatic serve(input logic [15:0] c, input logic [31:0] h,
                       input bit ret);
    int n;
    n = 0;
    dly <= rnd() % 4;
    while (evt_valid !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    `CHK("code", c, code)
    `CHK("handler", h, hnd)
    while (evt_valid === 1'b1 && n < 160) begin
      @(negedge clk);
      n++;
    end
    if (c == 16'h0010) `CHK("nmi_return_pc", div ? cur : fol, nmi_return_pc)
    if (c >= 16'h0080) `CHK("maskable_return_pc", div ? cur : fol, maskable_return_pc)
    if (ret) begin
      @(posedge clk);
      reti <= 1'b1;
      @(posedge clk);
      reti <= 1'b0;
    end
  endtask

  task automatic quiet();
    repeat (12) @(negedge clk);
    `CHK("idle", 1'b0, evt_valid)
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    {rst, wr_s, rd_s, nmi, trap, undef, div, ei, reti} = 9'h100;
    {addr, vec, dly, wdata, cur, fol, preq, pins} = '0;
    rs = 32'hb8d9;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("rst flag", 1'b1, id_f)
    serve(16'h0000, 32'h0, 1);
    rd(6'h00, d);
    `CHK("ctl rst", 32'h47, d)
    rd(6'h3f, d);
    `CHK("unmapped", 32'h0, d)
    for (i = 0; i < 35; i++) begin
      wr(6'(i), 32'h0);
      req(35'h1 << i);
      serve(ecode(i), {16'h0, ecode(i)}, 1);
    end
    a = rnd() % 34;
    b = a + 1 + rnd() % (34 - a);
    wr(6'(a), 32'h3);
    wr(6'(b), 32'h3);
    req((35'h1 << a) | (35'h1 << b));
    serve(ecode(a), {16'h0, ecode(a)}, 1);
    serve(ecode(b), {16'h0, ecode(b)}, 1);
    wr(6'(b), 32'h1);
    req((35'h1 << a) | (35'h1 << b));
    serve(ecode(b), {16'h0, ecode(b)}, 1);
    serve(ecode(a), {16'h0, ecode(a)}, 1);
    i = rnd() % 35;
    wr(6'(i), 32'h42);
    req(35'h1 << i);
    quiet();
    wr(REG_PRIO_MASK, 32'h2);
    wr(6'(i), 32'h82);
    quiet();
    wr(REG_PRIO_MASK, 32'h8);
    serve(ecode(i), {16'h0, ecode(i)}, 1);
    for (a = 0; a < 32; a++) begin
      @(posedge clk);
      trap <= 1'b1;
      vec <= 5'(a);
      @(posedge clk);
      trap <= 1'b0;
      serve(a < 16 ? 16'h0040 + 16'(a) : 16'h0050 + 16'(a - 16), a < 16 ?
        32'h40 : 32'h50, 1);
    end
    @(posedge clk);
    {undef, trap, vec, preq} <= {2'h3, 5'h05, 35'h1 << i};
    @(posedge clk);
    {undef, trap, preq} <= '0;
    serve(16'h0060, 32'h60, 1);
    serve(16'h0045, 32'h40, 1);
    serve(ecode(i), {16'h0, ecode(i)}, 1);
    req('0);
    nmi <= 1'b1;
    quiet();
    nmi <= 1'b0;
    serve(16'h0010, 32'h10, 0);
    `CHK("np", 1'b1, np_f)
    repeat (2) begin
      repeat (6) @(posedge clk);
      nmi <= 1'b1;
      repeat (6) @(posedge clk);
      nmi <= 1'b0;
    end
    repeat (8) @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    serve(16'h0010, 32'h10, 1);
    quiet();
    wr(REG_EXT_MODE, 32'h1);
    nmi <= 1'b1;
    serve(16'h0010, 32'h10, 1);
    wr(REG_TUM0, 32'h1);
    wr(REG_PIN_EDGE, 32'h1);
    wr(6'h04, 32'h80);
    req(35'h10);
    quiet();
    pins <= 9'h001;
    serve(ecode(4), {16'h0, ecode(4)}, 1);
    finish_test();
  end
endmodule
`default_nettype wire
